// >>> hdl/pms_pkg.sv
`default_nettype none

package pms_pkg;

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam int unsigned PMS_NREGS = 32;          // Direct register count
  localparam int unsigned PMS_AW = 5;              // Register address width
  localparam int unsigned PMS_DW = 16;             // Register data width
  localparam logic [4:0] PMS_REG_VEND_CTRL = 5'h16;  // Broadcast control word
  localparam logic [4:0] PMS_REG_IRQ = 5'h1B;      // interrupt_enable_and_flags
  localparam logic [4:0] PMS_REG_PHY_CTRL2 = 5'h1F;  // Interrupt polarity word
  localparam int unsigned PMS_BCAST_OFF_BIT = 9;   // Bit position in 16h
  localparam int unsigned PMS_IRQ_POL_BIT = 9;     // Bit position in 1Fh
  localparam logic [15:0] PMS_REG_RESET = 16'h0000;  // Storage value after reset
  localparam logic [7:0] PMS_IRQ_EN_RESET = 8'h00;   // Enables after reset
  localparam logic [7:0] PMS_IRQ_ST_RESET = 8'h00;   // Flags after reset

  // ----------------------------------------------------------------
  // Frame format
  // ----------------------------------------------------------------
  localparam logic [5:0] PMS_PREAMBLE_ONES = 6'h20;  // Ones before a start code
  localparam logic [1:0] PMS_OP_READ = 2'h2;        // Opcode 10
  localparam logic [1:0] PMS_OP_WRITE = 2'h1;       // Opcode 01
  localparam logic [3:0] PMS_FIELD_LAST = 4'h4;     // Last bit of 5-bit field
  localparam logic [3:0] PMS_DATA_LAST = 4'hF;      // Last of sixteen data bits
  localparam logic [1:0] PMS_STRAP_WAIT = 2'h3;     // Cycles before strap capture

  // Frame walk, Gray coded from idle through data; the step from data back to idle flips two bits
  typedef enum logic [2:0] {
    PMS_IDLE = 3'h0,
    PMS_START = 3'h1,
    PMS_OPC = 3'h3,
    PMS_PHYA = 3'h2,
    PMS_REGA = 3'h6,
    PMS_TURN = 3'h7,
    PMS_DATA = 3'h5
  } pms_state_t;

  // Header fields collected from one frame
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } pms_hdr_t;

endpackage : pms_pkg

`default_nettype wire

// >>> hdl/pms_regmem.sv
`default_nettype none

// ------------------------------------------------------------------
// General register storage, one write port and a registered read
// ------------------------------------------------------------------
module pms_regmem
  import pms_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WE,
  input wire logic [4:0] WADDR,
  input wire logic [15:0] WDATA,
  input wire logic RE,
  input wire logic [4:0] RADDR,
  output logic [15:0] RDATA
);

  logic [15:0] mem_q [PMS_NREGS];  // Storage words

  // Words are reset so that every register reads a defined value at once
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < PMS_NREGS; i++) begin
        mem_q[i] <= PMS_REG_RESET;
      end
    end else if (WE) begin
      mem_q[WADDR] <= WDATA;
    end
  end

  // Read data held in a register until the next read
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= PMS_REG_RESET;
    end else if (RE) begin
      RDATA <= mem_q[RADDR];
    end
  end

endmodule : pms_regmem

`default_nettype wire

// >>> hdl/pms_serial.sv
`default_nettype none

// ------------------------------------------------------------------
// Management serial slave with interrupt flags
// ------------------------------------------------------------------
module pms_serial
  import pms_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE,
  input wire logic [2:0] STATION_ADDR_STRAPS,
  input wire logic BROADCAST_DISABLE_STRAP,
  input wire logic [7:0] EVENT_IN,
  output logic IRQ_OUT_PIN
);

  // ----------------------------------------------------------------
  // Synchronisers for pins
  // ----------------------------------------------------------------
  logic mdc_s1_q, mdc_s2_q, mdc_s3_q;  // Clock line, third stage for edges
  logic mdio_s1_q, mdio_s2_q;          // Data line
  logic [3:0] strap_s1_q, strap_s2_q;  // Address and broadcast straps

  // Two stages before any logic; the second stage is looked at, and the clock line's edge detector also uses the third
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      mdc_s1_q <= MDC;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= MDIO_I;
      mdio_s2_q <= mdio_s1_q;
      strap_s1_q <= {BROADCAST_DISABLE_STRAP, STATION_ADDR_STRAPS};
      strap_s2_q <= strap_s1_q;
    end
  end

  // Receiving side samples on the clock's rising edge
  wire mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire bit_in = mdio_s2_q;

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_q;     // Waits for the synchroniser to fill
  logic [2:0] own_addr_q;      // Latched station address
  logic bcast_strap_off_q;     // Latched broadcast disable strap

  // Straps are loaded on each of the first three cycles after release, then held; never under reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_cnt_q <= 2'h0;
      own_addr_q <= 3'h0;
      bcast_strap_off_q <= 1'b0;
    end else if (strap_cnt_q != PMS_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      own_addr_q <= strap_s2_q[2:0];
      bcast_strap_off_q <= strap_s2_q[3];
    end
  end

  // ----------------------------------------------------------------
  // Control bits and interrupt flags
  // ----------------------------------------------------------------
  logic bcast_sw_off_q;  // Software broadcast disable
  logic irq_pol_q;       // 1: pin active high
  logic [7:0] irq_en_q;  // Per-condition enables
  logic [7:0] irq_st_q;  // Sticky condition flags
  logic irq_clr;         // Read of flag register in progress
  logic wr_commit;       // Write accepted this cycle
  logic [4:0] wr_addr;
  logic [15:0] wr_data;

  wire wr_vend = wr_commit && (wr_addr == PMS_REG_VEND_CTRL);
  wire wr_ctrl2 = wr_commit && (wr_addr == PMS_REG_PHY_CTRL2);
  wire wr_irq = wr_commit && (wr_addr == PMS_REG_IRQ);

  // Shadow copies of control bits that steer logic every cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bcast_sw_off_q <= 1'b0;
      irq_pol_q <= 1'b0;
      irq_en_q <= PMS_IRQ_EN_RESET;
    end else begin
      if (wr_vend) begin
        bcast_sw_off_q <= wr_data[PMS_BCAST_OFF_BIT];
      end
      if (wr_ctrl2) begin
        irq_pol_q <= wr_data[PMS_IRQ_POL_BIT];
      end
      if (wr_irq) begin
        irq_en_q <= wr_data[15:8];
      end
    end
  end

  // New events win over a clear landing in the same cycle
  wire [7:0] irq_st_d = (irq_clr ? 8'h00 : irq_st_q) | EVENT_IN;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_st_q <= PMS_IRQ_ST_RESET;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  // Only enabled flags reach the pin; level chosen by software
  wire irq_active = |(irq_en_q & irq_st_q);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_OUT_PIN <= 1'b1;  // Inactive level for default active low
    end else begin
      IRQ_OUT_PIN <= irq_pol_q ? irq_active : ~irq_active;
    end
  end

  // ----------------------------------------------------------------
  // Frame receiver and responder
  // ----------------------------------------------------------------
  pms_state_t state_q, state_d;
  pms_hdr_t hdr_q;          // Collected header
  logic [5:0] ones_q;       // Preamble ones, saturating
  logic [3:0] cnt_q;        // Bit count inside a field
  logic [15:0] shift_q;     // Data shifter, both directions
  logic [15:0] rd_word;     // Word chosen for a read answer
  logic [15:0] mem_rdata;
  logic mem_re;

  // Own address, plus zero while broadcast is on; zero then also unique
  wire bcast_on = ~bcast_strap_off_q & ~bcast_sw_off_q;
  wire addr_hit = (hdr_q.phy == {2'h0, own_addr_q})
                || (bcast_on && (hdr_q.phy == 5'h00));
  wire is_read = (hdr_q.op == PMS_OP_READ);
  wire is_write = (hdr_q.op == PMS_OP_WRITE);
  wire field_end = (cnt_q == PMS_FIELD_LAST);
  wire data_end = (cnt_q == PMS_DATA_LAST);
  wire preamble_ok = (ones_q == PMS_PREAMBLE_ONES);
  wire read_serv = addr_hit && is_read;

  // Flag register answers from its own flops, the rest from storage
  assign rd_word = (hdr_q.regad == PMS_REG_IRQ) ? {irq_en_q, irq_st_q} : mem_rdata;
  assign mem_re = mdc_rise && (state_q == PMS_REGA) && field_end;
  assign irq_clr = mdc_rise && (state_q == PMS_TURN) && (cnt_q == 4'h0)
                 && read_serv && (hdr_q.regad == PMS_REG_IRQ);
  assign wr_commit = mdc_rise && (state_q == PMS_DATA) && data_end
                   && addr_hit && is_write;
  assign wr_addr = hdr_q.regad;
  assign wr_data = {shift_q[14:0], bit_in};

  // Next state on each sampled rising edge
  always_comb begin
    state_d = state_q;
    if (mdc_rise) begin
      case (state_q)
        PMS_IDLE: begin
          if (!bit_in && preamble_ok) state_d = PMS_START;
        end
        PMS_START: begin
          state_d = bit_in ? PMS_OPC : PMS_IDLE;  // Second start bit must be 1
        end
        PMS_OPC: begin
          if (cnt_q == 4'h1) begin
            // Opcodes 00 and 11 are not frames this slave answers
            state_d = ({hdr_q.op[0], bit_in} == PMS_OP_READ
                      || {hdr_q.op[0], bit_in} == PMS_OP_WRITE) ? PMS_PHYA : PMS_IDLE;
          end
        end
        PMS_PHYA: begin
          if (field_end) state_d = PMS_REGA;
        end
        PMS_REGA: begin
          if (field_end) state_d = PMS_TURN;
        end
        PMS_TURN: begin
          if (cnt_q == 4'h1) state_d = PMS_DATA;
        end
        PMS_DATA: begin
          if (data_end) state_d = PMS_IDLE;
        end
        default: state_d = PMS_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= PMS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Preamble counter, any zero outside a start code restarts it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ones_q <= 6'h00;
    end else if (mdc_rise) begin
      if (state_q != PMS_IDLE || !bit_in) begin
        ones_q <= 6'h00;
      end else if (!preamble_ok) begin
        ones_q <= ones_q + 6'h01;
      end
    end
  end

  // Field bit counter restarts whenever the state changes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= 4'h0;
    end else if (mdc_rise) begin
      cnt_q <= (state_d != state_q) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Header collection, MSB first
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hdr_q <= '0;
    end else if (mdc_rise) begin
      case (state_q)
        PMS_OPC: hdr_q.op <= {hdr_q.op[0], bit_in};
        PMS_PHYA: hdr_q.phy <= {hdr_q.phy[3:0], bit_in};
        PMS_REGA: hdr_q.regad <= {hdr_q.regad[3:0], bit_in};
        default: hdr_q <= hdr_q;
      endcase
    end
  end

  // Shifter: loads the answer at the first turnaround edge, else shifts during turnaround and data
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      shift_q <= 16'h0000;
    end else if (mdc_rise) begin
      if (state_q == PMS_TURN && cnt_q == 4'h0) begin
        shift_q <= rd_word;
      end else if (state_q == PMS_DATA || state_q == PMS_TURN) begin
        shift_q <= {shift_q[14:0], bit_in};
      end
    end
  end

  // Line driver. Changes land just after a sampled rising edge, so the
  // value settles well before the controller's next rising edge. The
  // synchroniser delay eats about three cycles of a half period, which
  // limits the clock line to roughly one sixth of the system clock.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MDIO_OE <= 1'b0;
      MDIO_O <= 1'b1;
    end else if (mdc_rise) begin
      if (state_q == PMS_TURN && cnt_q == 4'h0 && read_serv) begin
        MDIO_OE <= 1'b1;
        MDIO_O <= 1'b0;   // Second turnaround bit
      end else if (MDIO_OE && state_q == PMS_DATA && data_end) begin
        MDIO_OE <= 1'b0;  // Release after the last bit
        MDIO_O <= 1'b1;
      end else if (MDIO_OE) begin
        MDIO_O <= shift_q[15];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  pms_regmem u_regmem (
    .CLK(CLK),
    .RSTN(RSTN),
    .WE(wr_commit),
    .WADDR(wr_addr),
    .WDATA(wr_data),
    .RE(mem_re),
    .RADDR({hdr_q.regad[3:0], bit_in}),
    .RDATA(mem_rdata)
  );

endmodule : pms_serial

`default_nettype wire

// >>> verification/pms_serial_properties.sv
`default_nettype none
// ----------------------------------------------------------------
// Link and interrupt checks
// ----------------------------------------------------------------
module pms_serial_properties
  import pms_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic MDC,
  input wire logic MDIO_I,
  input wire logic MDIO_O,
  input wire logic MDIO_OE,
  input wire logic [2:0] STATION_ADDR_STRAPS,
  input wire logic BROADCAST_DISABLE_STRAP,
  input wire logic [7:0] EVENT_IN,
  input wire logic IRQ_OUT_PIN
);
  logic mdc_q; // Previous MDC pin level
  logic oe_q; // Previous drive enable
  logic [3:0] sr_q; // Cycles since MDC pin rose, saturating
  logic [4:0] cnt_q; // MDC rises seen while driving
  wire mdc_rise = MDC && !mdc_q; // Raw pin edge, ahead of the block's synchronisers
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Edge trackers; saturation keeps old frames from aliasing
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mdc_q <= 1'b0;
      oe_q <= 1'b0;
      sr_q <= 4'hF;
      cnt_q <= 5'h00;
    end else begin
      mdc_q <= MDC;
      oe_q <= MDIO_OE;
      if (mdc_rise) sr_q <= 4'h0;
      else if (sr_q != 4'hF) sr_q <= sr_q + 4'h1;
      if (MDIO_OE && !oe_q) cnt_q <= 5'h00;
      else if (MDIO_OE && mdc_rise) cnt_q <= cnt_q + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_turn_zero: assert property ($rose(MDIO_OE) |-> !MDIO_O)
    else $error("first driven bit is not zero");
  a_drive_span: assert property ($fell(MDIO_OE) |-> cnt_q == 5'h11)
    else $error("drive span is not turnaround plus sixteen bits");
  a_drive_gap: assert property ($fell(MDIO_OE) |-> !MDIO_OE [*8])
    else $error("line taken again too soon");
  a_released_high: assert property (!MDIO_OE |-> MDIO_O)
    else $error("output not high while released");
  a_quiet_released: assert property ($changed(MDIO_O) |->
      MDIO_OE || $fell(MDIO_OE))
    else $error("output moved while released");
  a_take_after_rise: assert property ($rose(MDIO_OE) |->
      sr_q inside {[4'h1:4'h6]})
    else $error("drive start not tied to an MDC rise");
  a_bit_after_rise: assert property (MDIO_OE && $changed(MDIO_O) |->
      sr_q inside {[4'h1:4'h6]})
    else $error("data bit changed away from an MDC rise");
  a_irq_cause: assert property ($changed(IRQ_OUT_PIN) |->
      $past(EVENT_IN) != 8'h00 || $past(EVENT_IN, 2) != 8'h00 || sr_q < 4'hC)
    else $error("interrupt pin moved without a cause");
  c_read_frame: cover property ($fell(MDIO_OE));
  c_irq_rise: cover property ($rose(IRQ_OUT_PIN));
  c_irq_fall: cover property ($fell(IRQ_OUT_PIN));
endmodule // pms_serial_properties

bind pms_serial pms_serial_properties pms_serial_properties_inst (
  .CLK(CLK), .RSTN(RSTN), .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O),
  .MDIO_OE(MDIO_OE), .STATION_ADDR_STRAPS(STATION_ADDR_STRAPS),
  .BROADCAST_DISABLE_STRAP(BROADCAST_DISABLE_STRAP), .EVENT_IN(EVENT_IN),
  .IRQ_OUT_PIN(IRQ_OUT_PIN));
`default_nettype wire

// >>> verification/pms_mgmt_master.sv
`default_nettype none
// ----------------------------------------------------------------
// Management controller model
// ----------------------------------------------------------------
module pms_mgmt_master
  import pms_pkg::*;
(
  input wire logic CLK,
  input wire logic DUT_O,
  input wire logic DUT_OE,
  output logic MDC,
  output logic MDIO
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_o = 1'b1; // Level the controller puts on the line
  logic m_oe = 1'b0; // Controller owns the line
  // Pull-up wins when nobody drives
  assign MDIO = DUT_OE ? DUT_O : (m_oe ? m_o : 1'b1);
  // Clock stands low between frames
  initial begin
    MDC = 1'b0;
  end
  // One whole frame; bits change at MDC fall and are taken at MDC rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    // Low and high phases of four clocks each give a 320 ns period
    for (int i = 0; i < 64; i++) begin
      @(negedge CLK);
      MDC = 1'b0;
      m_oe = (op == PMS_OP_WRITE) || (i < 46);
      m_o = f[63-i];
      repeat (4) @(negedge CLK);
      if (i == 47) ta = MDIO;
      if (i > 47) rd[63-i] = MDIO;
      MDC = 1'b1;
      repeat (3) @(negedge CLK);
    end
    @(negedge CLK);
    MDC = 1'b0;
    m_oe = 1'b0;
    m_o = 1'b1;
    repeat (8) @(negedge CLK);
  endtask
endmodule // pms_mgmt_master
`default_nettype wire

// >>> verification/testbench.sv
`default_nettype none
module testbench
  import pms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // 25 MHz system clock
  logic rstn = 1'b0; // Active-low reset
  logic [2:0] straps = 3'h5; // Own address straps
  logic bdis = 1'b0; // Broadcast-disable strap
  logic [7:0] event_in = 8'h00; // Condition pulses
  wire mdc; // Management clock from the controller
  wire mdio; // Resolved data line
  wire mdio_o; // Block's data drive
  wire mdio_oe; // Block's drive enable
  wire irq; // Interrupt pin
  int n_mismatch = 0; // Mismatches seen
  int n_compared = 0; // Comparisons made
  localparam logic [4:0] RA [4] = '{5'h00, 5'h0E, 5'h1D, 5'h03}; // Spread over the space
  pms_serial pms_serial_inst (.CLK(clk), .RSTN(rstn), .MDC(mdc), .MDIO_I(mdio),
    .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .STATION_ADDR_STRAPS(straps),
    .BROADCAST_DISABLE_STRAP(bdis), .EVENT_IN(event_in), .IRQ_OUT_PIN(irq));
  pms_mgmt_master pms_mgmt_master_inst (.CLK(clk), .DUT_O(mdio_o), .DUT_OE(mdio_oe),
    .MDC(mdc), .MDIO(mdio));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Compare, access and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    logic t;
    pms_mgmt_master_inst.xfer(PMS_OP_WRITE, phy, ra, d, x, t);
  endtask
  // A foreign read sees the pull-up: turnaround 1 and all-ones data
  task automatic rdc(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp,
      input logic ta_exp);
    logic [15:0] d;
    logic t;
    pms_mgmt_master_inst.xfer(PMS_OP_READ, phy, ra, 16'h0000, d, t);
    chk1("turnaround bit", ta_exp, t);
    chk16("read data", exp, d);
  endtask
  task automatic pulse(input logic [7:0] ev);
    @(negedge clk);
    event_in = ev;
    @(negedge clk);
    event_in = 8'h00;
    repeat (3) @(negedge clk);
  endtask
  task automatic do_reset(input logic [2:0] s, input logic b);
    @(negedge clk);
    rstn = 1'b0;
    straps = s;
    bdis = b;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(3'h5, 1'b0);
    chk1("irq after reset", 1'b1, irq);
    rdc(5'h05, PMS_REG_IRQ, 16'h0000, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) wr(5'h05, RA[i], 16'hA5C3 ^ 16'(i));
    for (int i = 0; i < 4; i++) rdc(5'h05, RA[i], 16'hA5C3 ^ 16'(i), 1'b0);
    $display("test storage done");
    wr(5'h00, 5'h02, 16'h1234);
    rdc(5'h05, 5'h02, 16'h1234, 1'b0);
    rdc(5'h00, 5'h02, 16'h1234, 1'b0);
    wr(5'h03, 5'h02, 16'hFFFF);
    wr(5'h0D, 5'h02, 16'hFFFF);
    rdc(5'h05, 5'h02, 16'h1234, 1'b0);
    rdc(5'h03, 5'h02, 16'hFFFF, 1'b1);
    $display("test addressing done");
    wr(5'h05, PMS_REG_VEND_CTRL, 16'h0200);
    wr(5'h00, 5'h02, 16'h5555);
    rdc(5'h05, 5'h02, 16'h1234, 1'b0);
    rdc(5'h00, 5'h02, 16'hFFFF, 1'b1);
    wr(5'h05, PMS_REG_VEND_CTRL, 16'h0000);
    $display("test broadcast bit done");
    pulse(8'h01);
    chk1("irq masked", 1'b1, irq);
    rdc(5'h05, PMS_REG_IRQ, 16'h0001, 1'b0);
    rdc(5'h05, PMS_REG_IRQ, 16'h0000, 1'b0);
    wr(5'h05, PMS_REG_IRQ, 16'h0255);
    pulse(8'h02);
    chk1("irq asserted low", 1'b0, irq);
    rdc(5'h05, PMS_REG_IRQ, 16'h0202, 1'b0);
    chk1("irq cleared", 1'b1, irq);
    wr(5'h05, PMS_REG_PHY_CTRL2, 16'h0200);
    chk1("irq idle high mode", 1'b0, irq);
    pulse(8'h02);
    chk1("irq asserted high", 1'b1, irq);
    rdc(5'h05, PMS_REG_IRQ, 16'h0202, 1'b0);
    chk1("irq cleared high", 1'b0, irq);
    $display("test interrupt done");
    do_reset(3'h6, 1'b1);
    chk1("irq polarity reset", 1'b1, irq);
    wr(5'h00, 5'h02, 16'h5555);
    rdc(5'h06, 5'h02, 16'h0000, 1'b0);
    rdc(5'h00, 5'h02, 16'hFFFF, 1'b1);
    $display("test strap done");
    // Broadcast off and strapped to zero: zero is an ordinary own address
    do_reset(3'h0, 1'b1);
    wr(5'h00, 5'h02, 16'h5A5A);
    rdc(5'h00, 5'h02, 16'h5A5A, 1'b0);
    $display("test unique zero done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
